// ==== cbi_pkg.sv ====
/*
 Constants, cycle-type codes and carrier structs for the bus interface
 control block. Assumes one 10 MHz core clock and a synchronous reset.
*/
// Summary of operation
// (R1) Priority lines read as binary, bit0 LSB
// (R2) Level seven taken regardless of mask
// (R3) Requester holds level until acknowledge code
// (R4) Bus fault with halt picks rerun or exception
// (R5) Reset instruction drives reset line only
// (R6) External reset starts initialization sequence
// (R7) Halt plus reset together is full reset
// (R8) External halt stops after current cycle
// (R9) Halt floats address, data and cycle code; code floats data and code only, address stays driven
// (R10) Self-stop drives the halt line
// (R11) Enable period ten clocks, six low four high
// (R12) Enable ring counter runs free always; code holds it at ENABLE_RESET while rst_i is high
// (R13) Sync select during acknowledge means autovector
// (R14) Sync address valid only after sync select
// (R15) Three-bit cycle-type code encodings
// (R16) Cycle code valid while address strobe asserted
// (R17) Word reads assert both byte strobes
// (R18) Byte reads pick strobe by byte select bit
// (R19) Grant acknowledge floats all bus outputs
// (R20) Clock never gated, pulse widths kept
// (R21) Master deskews its signals and slave replies
// (R22) Acknowledge latches read data, ends cycle
// (R23) Acknowledge cycle puts level on low address
// (R24) Take interrupt only when above mask
package cbi_pkg;
    // Cycle-type codes and top interrupt level
    localparam logic [2:0] CT_USER_DATA = 3'h1;
    localparam logic [2:0] CT_USER_PROG = 3'h2;
    localparam logic [2:0] CT_SUP_DATA = 3'h5;
    localparam logic [2:0] CT_SUP_PROG = 3'h6;
    localparam logic [2:0] CT_INT_ACK = 3'h7;
    localparam logic [2:0] CT_RESET = 3'h0;
    localparam logic [2:0] LEVEL_TOP = 3'h7;
    // Enable divider phases
    localparam int ENABLE_LOW_CLKS = 6;
    localparam int ENABLE_HIGH_CLKS = 4;
    localparam int ENABLE_PERIOD_CLKS = ENABLE_LOW_CLKS + ENABLE_HIGH_CLKS;
    localparam logic [3:0] ENABLE_LAST = 4'(ENABLE_PERIOD_CLKS - 1);
    localparam logic [3:0] ENABLE_HIGH_FROM = 4'(ENABLE_LOW_CLKS);
    localparam logic [3:0] ENABLE_RESET = 4'h0;
    // Reset pulse from the reset instruction, in cycles
    localparam logic [7:0] RESET_OUT_CLKS = 8'h7C;
    // Constant upper address in acknowledge cycles
    localparam logic [19:0] ACK_ADDR_HIGH = 20'hFFFFF;

    typedef struct packed {
        logic [22:0] addr;   // Word address A1..A23
        logic [2:0] ctype;   // Cycle-type code
        logic is_read;
        logic is_byte;
        logic byte_sel;      // Internal lowest address bit
        logic [15:0] wdata;
    } cbi_req_t;

    typedef struct packed {
        logic [22:0] addr;
        logic [15:0] data;
        logic [2:0] ctype;
        logic strobe_n;
        logic upper_n;
        logic lower_n;
        logic rd_wr;
        logic valid_n;
    } cbi_bus_t;
endpackage

// ==== cbi_ctrl.sv ====
/*
 Bus interface control: enable divider, interrupt gating, cycle issue
 with strobes, halt/fault/reset handling and float enables.
 Assumes pins are synchronous to core_clk_i, active-low pins inverted.
*/
`timescale 1ns/100ps
`default_nettype none
module cbi_ctrl (
    input wire logic core_clk_i,            // 10 MHz core clock
    input wire logic rst_i,                 // Sync reset, active high
    input wire cbi_pkg::cbi_req_t req_i,    // Cycle request
    input wire logic req_valid_i,           // Request pending
    output logic req_ready_o,               // Request taken
    output logic [15:0] rdata_o,            // Aligned read data
    output logic done_o,                    // Cycle end pulse
    output logic autovec_o,                 // Autovector used
    output logic fault_o,                   // Exception on fault
    output logic rerun_o,                   // Rerun on fault+halt
    input wire logic [2:0] mask_i,          // Status register mask
    input wire logic [2:0] interrupt_priority_lines_i, // Active high
    output logic irq_take_o,                // Interrupt accepted
    output logic [2:0] irq_level_o,         // Registered line level
    input wire logic reset_instr_i,         // Reset instruction
    input wire logic stopped_i,             // Core has stopped
    output logic sys_init_o,                // Start initialization
    output logic full_reset_o,              // System-wide reset
    output cbi_pkg::cbi_bus_t bus_o,        // Bus outputs
    output logic bus_oe_o,                  // Addr/ctrl drive enable
    output logic data_oe_o,                 // Data drive enable
    output logic ctype_oe_o,                // Cycle code drive enable
    input wire logic [15:0] data_i,         // Data bus in
    input wire logic transfer_acknowledge_i, // Active high
    input wire logic bus_fault_input_i,     // Active high
    input wire logic sync_peripheral_select_i, // Active high
    input wire logic grant_acknowledge_input_i, // Active high
    input wire logic halt_i,                // Halt line in
    output logic halt_o,                    // Halt line out
    output logic halt_oe_o,                 // Halt drive enable
    input wire logic reset_line_i,          // Reset line in
    output logic reset_line_o,              // Reset line out
    output logic reset_line_oe_o,           // Reset drive enable
    output logic enable_o                   // Peripheral enable
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ACT = 4'h2,
        ST_SYNC = 4'h4,
        ST_HALT = 4'h8
    } cbi_state_t;

    cbi_state_t st_q, st_d;
    logic [3:0] ring_q, ring_d;
    logic en_q, en_d;
    cbi_pkg::cbi_req_t cur_q, cur_d;
    cbi_pkg::cbi_bus_t bus_q, bus_d;
    logic ready_q, ready_d, done_q, done_d, av_q, av_d;
    logic flt_q, flt_d, rer_q, rer_d;
    logic [15:0] rd_q, rd_d;
    logic take_q, take_d;
    logic [2:0] lvl_q, lvl_d;
    logic [7:0] rcnt_q, rcnt_d;
    logic init_q, init_d, full_q, full_d;
    logic boe_q, boe_d, doe_q, doe_d, coe_q, coe_d;
    logic hoe_q, hoe_d;
    logic rout_q, rout_d;
    logic enable_edge;

    // Enable divider; ring reset value is arbitrary phase
    always_comb
    begin
        // (R12) free-running ring
        ring_d = (ring_q == cbi_pkg::ENABLE_LAST) ? 4'h0 : ring_q + 4'h1;
        // (R11) six low, four high
        en_d = (ring_d >= cbi_pkg::ENABLE_HIGH_FROM);
    end
    // Sync transfers align to the last low clock before enable rises
    assign enable_edge = (ring_q == cbi_pkg::ENABLE_HIGH_FROM - 4'h1);

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            ring_q <= cbi_pkg::ENABLE_RESET;
            en_q <= 1'b0;
        end
        else
        begin
            ring_q <= ring_d;
            en_q <= en_d;
        end
    end

    // Interrupt acceptance against the mask
    always_comb
    begin
        // (R1) binary level, bit0 least significant
        lvl_d = interrupt_priority_lines_i;
        // (R24) above mask only; (R2) level seven never masked
        take_d = (lvl_d != 3'h0) &&
            ((lvl_d > mask_i) || (lvl_d == cbi_pkg::LEVEL_TOP));
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            take_q <= 1'b0;
            lvl_q <= 3'h0;
        end
        else
        begin
            take_q <= take_d;
            lvl_q <= lvl_d;
        end
    end

    // Reset and halt lines; self-reset never touches our own state
    always_comb
    begin
        rcnt_d = rcnt_q;
        // (R5) reset instruction pulses line out
        if (reset_instr_i && rcnt_q == 8'h0)
            rcnt_d = cbi_pkg::RESET_OUT_CLKS;
        else if (rcnt_q != 8'h0)
            rcnt_d = rcnt_q - 8'h1;
        // Registered so the reset pin comes straight from a flop
        rout_d = (rcnt_d != 8'h0);
        // (R6) outside reset starts init, ignoring our own drive
        init_d = reset_line_i && (rcnt_q == 8'h0);
        // (R7) halt with reset is a full reset
        full_d = init_d && halt_i;
        // (R10) drive halt when stopped
        hoe_d = stopped_i;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            rcnt_q <= 8'h0;
            init_q <= 1'b0;
            full_q <= 1'b0;
            hoe_q <= 1'b0;
            rout_q <= 1'b0;
        end
        else
        begin
            rcnt_q <= rcnt_d;
            init_q <= init_d;
            full_q <= full_d;
            hoe_q <= hoe_d;
            rout_q <= rout_d;
        end
    end

    // Bus cycle sequencer
    always_comb
    begin
        st_d = st_q;
        cur_d = cur_q;
        bus_d = bus_q;
        ready_d = 1'b0;
        done_d = 1'b0;
        av_d = 1'b0;
        flt_d = 1'b0;
        rer_d = 1'b0;
        rd_d = rd_q;
        unique case (st_q)
            ST_IDLE:
            begin
                // (R8) halt holds off new cycles
                if (halt_i && !grant_acknowledge_input_i)
                    st_d = ST_HALT;
                else if (req_valid_i && !grant_acknowledge_input_i &&
                    !init_q && !ready_q)
                begin
                    ready_d = 1'b1;
                    cur_d = req_i;
                    st_d = ST_ACT;
                    bus_d.addr = req_i.addr;
                    // (R23) level on low lines, rest high
                    if (req_i.ctype == cbi_pkg::CT_INT_ACK)
                        bus_d.addr = {cbi_pkg::ACK_ADDR_HIGH, lvl_q};
                    // (R15) code from request
                    bus_d.ctype = req_i.ctype;
                    bus_d.data = req_i.wdata;
                    bus_d.rd_wr = req_i.is_read;
                    bus_d.strobe_n = 1'b0;
                    // (R17) word: both strobes; (R18) byte: by select bit
                    bus_d.upper_n = req_i.is_byte && req_i.byte_sel;
                    bus_d.lower_n = req_i.is_byte && !req_i.byte_sel;
                end
            end
            ST_ACT:
            begin
                // (R4) fault with halt reruns, alone faults
                if (bus_fault_input_i)
                begin
                    rer_d = halt_i;
                    flt_d = !halt_i;
                    st_d = ST_IDLE;
                end
                // (R13) sync select in acknowledge: autovector
                else if (sync_peripheral_select_i)
                begin
                    if (cur_q.ctype == cbi_pkg::CT_INT_ACK)
                    begin
                        av_d = 1'b1;
                        done_d = 1'b1;
                        st_d = ST_IDLE;
                    end
                    else
                        st_d = ST_SYNC;
                end
                // (R22) acknowledge latches read data and ends cycle
                else if (transfer_acknowledge_i)
                begin
                    done_d = 1'b1;
                    st_d = ST_IDLE;
                    if (cur_q.is_read)
                        rd_d = (cur_q.is_byte) ? (cur_q.byte_sel ?
                            {8'h00, data_i[7:0]} :
                            {8'h00, data_i[15:8]}) : data_i;
                end
            end
            ST_SYNC:
            begin
                // (R14) valid address only after select and alignment
                if (enable_edge)
                    bus_d.valid_n = 1'b0;
                if (!bus_q.valid_n && en_q && !en_d)
                begin
                    done_d = 1'b1;
                    st_d = ST_IDLE;
                    if (cur_q.is_read)
                        rd_d = (cur_q.is_byte) ? (cur_q.byte_sel ?
                            {8'h00, data_i[7:0]} :
                            {8'h00, data_i[15:8]}) : data_i;
                end
            end
            ST_HALT:
            begin
                if (!halt_i)
                    st_d = ST_IDLE;
            end
            default:
                st_d = ST_IDLE;
        endcase
        // Close strobes when the cycle ends
        if (st_d != ST_ACT && st_d != ST_SYNC)
        begin
            bus_d.strobe_n = 1'b1;
            bus_d.upper_n = 1'b1;
            bus_d.lower_n = 1'b1;
            bus_d.valid_n = 1'b1;
            bus_d.rd_wr = 1'b1;
        end
        // (R19) grant acknowledge floats all bus outputs
        boe_d = !grant_acknowledge_input_i;
        // (R9) halt floats data and code; address stays driven
        doe_d = boe_d && (st_d != ST_HALT) && !bus_d.rd_wr;
        // (R16) code driven while strobe asserted
        coe_d = boe_d && (st_d != ST_HALT);
    end

    // (R21) all outputs and sampled replies pass through registers
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            st_q <= ST_IDLE;
            cur_q <= '0;
            bus_q <= '{addr: 23'h0, data: 16'h0,
                ctype: cbi_pkg::CT_RESET, strobe_n: 1'b1, upper_n: 1'b1,
                lower_n: 1'b1, rd_wr: 1'b1, valid_n: 1'b1};
            ready_q <= 1'b0;
            done_q <= 1'b0;
            av_q <= 1'b0;
            flt_q <= 1'b0;
            rer_q <= 1'b0;
            rd_q <= 16'h0;
            boe_q <= 1'b0;
            doe_q <= 1'b0;
            coe_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            cur_q <= cur_d;
            bus_q <= bus_d;
            ready_q <= ready_d;
            done_q <= done_d;
            av_q <= av_d;
            flt_q <= flt_d;
            rer_q <= rer_d;
            rd_q <= rd_d;
            boe_q <= boe_d;
            doe_q <= doe_d;
            coe_q <= coe_d;
        end
    end

    assign req_ready_o = ready_q;
    assign rdata_o = rd_q;
    assign done_o = done_q;
    assign autovec_o = av_q;
    assign fault_o = flt_q;
    assign rerun_o = rer_q;
    assign irq_take_o = take_q;
    assign irq_level_o = lvl_q;
    assign sys_init_o = init_q;
    assign full_reset_o = full_q;
    assign bus_o = bus_q;
    assign bus_oe_o = boe_q;
    assign data_oe_o = doe_q;
    assign ctype_oe_o = coe_q;
    assign halt_o = hoe_q;
    assign halt_oe_o = hoe_q;
    assign reset_line_o = rout_q;
    assign reset_line_oe_o = rout_q;
    assign enable_o = en_q;
endmodule
`default_nettype wire

// ==== cbi_chk.sv ====
/*
 Port checker for cbi_ctrl.
 Assumes it is bound to every cbi_ctrl instance.
*/
`timescale 1ns/100ps
`default_nettype none
module cbi_chk (
    input wire logic core_clk_i,                  // Clock
    input wire logic rst_i,                       // Reset
    input wire cbi_pkg::cbi_req_t req_i,          // Request
    input wire logic req_ready_o,                 // Taken
    input wire logic done_o,                      // Cycle end
    input wire logic irq_take_o,                  // Accepted
    input wire logic [2:0] irq_level_o,           // Level
    input wire logic [2:0] interrupt_priority_lines_i, // Lines
    input wire cbi_pkg::cbi_bus_t bus_o,          // Bus
    input wire logic bus_oe_o,                    // Bus enable
    input wire logic data_oe_o,                   // Data enable
    input wire logic ctype_oe_o,                  // Code enable
    input wire logic transfer_acknowledge_i,      // Ack
    input wire logic bus_fault_input_i,           // Fault
    input wire logic sync_peripheral_select_i,    // Sync select
    input wire logic grant_acknowledge_input_i,   // Grant ack
    input wire logic halt_i,                      // Halt line
    input wire logic reset_line_oe_o,             // Reset drive
    input wire logic enable_o                     // Enable
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // Checks tie outputs to causes, some with fixed repeat counts
    chk_enable_shape: assert property (
        $rose(enable_o) |-> enable_o[*4] ##1 !enable_o[*6] ##1 enable_o)
        else $error("enable shape wrong");
    chk_top_level: assert property (
        (interrupt_priority_lines_i == 3'h7)[*3] |-> irq_take_o)
        else $error("level seven not taken");
    chk_take_nonzero: assert property (
        irq_take_o |-> irq_level_o != 3'h0)
        else $error("take with level zero");
    chk_halt_float: assert property (
        halt_i[*5] |-> !ctype_oe_o && !data_oe_o)
        else $error("outputs driven in halt");
    chk_grant_float: assert property (
        grant_acknowledge_input_i[*2] |-> !bus_oe_o && !ctype_oe_o
        && !data_oe_o)
        else $error("outputs driven on grant");
    chk_code_hold: assert property (
        !bus_o.strobe_n && $past(!bus_o.strobe_n) |-> ctype_oe_o
        && $stable(bus_o.ctype))
        else $error("code moved under strobe");
    chk_word_strobes: assert property (
        req_ready_o && !req_i.is_byte |-> !bus_o.upper_n && !bus_o.lower_n)
        else $error("word strobes wrong");
    chk_byte_strobe: assert property (
        req_ready_o && req_i.is_byte |-> bus_o.upper_n == req_i.byte_sel
        && bus_o.lower_n == !req_i.byte_sel)
        else $error("byte strobe wrong");
    chk_valid_after: assert property (
        $fell(bus_o.valid_n) |-> $past(sync_peripheral_select_i))
        else $error("valid without select");
    chk_ack_done: assert property (
        transfer_acknowledge_i && !bus_o.strobe_n && bus_o.valid_n
        && !bus_fault_input_i && !sync_peripheral_select_i |=> done_o)
        else $error("ack did not end cycle");
    chk_reset_pulse: assert property (
        $rose(reset_line_oe_o) |-> reset_line_oe_o[*8])
        else $error("reset pulse short");
    cover property (done_o);
    cover property (irq_take_o);
    cover property (!bus_o.valid_n);
endmodule
bind cbi_ctrl cbi_chk chk_u (.*);
`default_nettype wire

// ==== cbi_mem.sv ====
/*
 Memory model answering cbi_ctrl read cycles after a set wait.
 Assumes the design's bus struct and an active-high acknowledge.
*/
`timescale 1ns/100ps
`default_nettype none
module cbi_mem (
    input wire logic core_clk_i,         // Clock
    input wire cbi_pkg::cbi_bus_t bus_i, // Device bus
    input wire logic [7:0] dly_i,        // Wait, FF never answers
    output logic ack_o = 1'b0,           // Transfer acknowledge
    output logic [15:0] data_o = 16'h0   // Read data
);
    logic [7:0] cnt_q = 8'h00;
    // data stable under ack
    // Released bus toggles so stale data never looks valid
    always @(posedge core_clk_i)
    begin
        if (bus_i.strobe_n)
        begin
            cnt_q <= 8'h00;
            ack_o <= 1'b0;
            data_o <= ~data_o;
        end
        else if (cnt_q >= dly_i && dly_i != 8'hFF)
        begin
            ack_o <= 1'b1;
            data_o <= {bus_i.addr[7:0] ^ 8'hA5, bus_i.addr[7:0]};
        end
        else
        begin
            cnt_q <= cnt_q + 8'h01;
            data_o <= ~data_o;
        end
    end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
/*
 Self-checking bench for cbi_ctrl with a memory model.
 Assumes cbi_pkg, cbi_ctrl, cbi_mem and cbi_chk compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    cbi_pkg::cbi_req_t req_i = '0;
    logic req_valid_i = 1'b0, reset_instr_i = 1'b0, stopped_i = 1'b0;
    logic bus_fault_input_i = 1'b0, sync_peripheral_select_i = 1'b0;
    logic grant_acknowledge_input_i = 1'b0, ext_halt = 1'b0;
    logic ext_reset = 1'b0;
    logic [2:0] mask_i = 3'h0, interrupt_priority_lines_i = 3'h0;
    logic [7:0] dly = 8'h00;
    logic req_ready_o, done_o, autovec_o, fault_o, rerun_o, irq_take_o;
    logic sys_init_o, full_reset_o, bus_oe_o, data_oe_o, ctype_oe_o;
    logic halt_o, halt_oe_o, reset_line_o, reset_line_oe_o, enable_o;
    logic transfer_acknowledge_i, halt_i, reset_line_i;
    logic [15:0] rdata_o, data_i;
    logic [2:0] irq_level_o;
    cbi_pkg::cbi_bus_t bus_o;
    int n_mismatch = 0;
    int checks = 0;
    // Wired lines: either party may pull them
    assign halt_i = ext_halt | (halt_oe_o & halt_o);
    assign reset_line_i = ext_reset | (reset_line_oe_o & reset_line_o);
    cbi_ctrl dut_u (.*);
    cbi_mem mem_u (.core_clk_i, .bus_i(bus_o), .dly_i(dly),
        .ack_o(transfer_acknowledge_i), .data_o(data_i));
    always #50 core_clk_i = ~core_clk_i;
    // Inputs move 10 ns after the edge, away from sampling
    task automatic step(input int k = 1);
        repeat (k) @(posedge core_clk_i);
        #10;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    function automatic logic sig(input int k);
        case (k)
            0: return req_ready_o === 1'b1;
            1: return done_o === 1'b1;
            2: return fault_o === 1'b1;
            3: return rerun_o === 1'b1;
            4: return autovec_o === 1'b1;
            5: return bus_o.valid_n === 1'b0;
            default: return reset_line_oe_o === 1'b1;
        endcase
    endfunction
    // Bounded wait for one of the status signals chosen by k
    task automatic wt(input int k);
        int n;
        n = 0;
        do
        begin
            step();
            n++;
        end
        while (!sig(k) && n < 60);
        cmp(n < 60, 1);
    endtask
    task automatic go(input logic [2:0] ct, input logic b, input logic s);
        req_i = '{{20'h3A5C1, ct}, ct, 1'b1, b, s, 16'h0};
        req_valid_i = 1'b1;
        wt(0);
        req_valid_i = 1'b0;
        cmp(bus_o.ctype, ct);
        cmp(bus_o.rd_wr, 1'b1);
    endtask
    task automatic rd(input logic [2:0] ct, input logic b, input logic s);
        logic [15:0] e;
        go(ct, b, s);
        wt(1);
        e = {req_i.addr[7:0] ^ 8'hA5, req_i.addr[7:0]};
        if (!b)
            cmp(rdata_o, e);
        else
            cmp(rdata_o[7:0], s ? e[7:0] : e[15:8]);
        step();
    endtask
    task automatic t_enable();
        int hi;
        int lo;
        hi = 0;
        lo = 0;
        for (int i = 0; i < 12 && enable_o !== 1'b0; i++)
            step();
        for (int i = 0; i < 12 && enable_o !== 1'b1; i++)
            step();
        while (enable_o === 1'b1 && hi < 12)
        begin
            step();
            hi++;
        end
        while (enable_o === 1'b0 && lo < 12)
        begin
            step();
            lo++;
        end
        cmp(hi, 4);
        cmp(lo, 6);
    endtask
    task automatic t_irq();
        logic [2:0] lv [5] = '{3'h7, 3'h3, 3'h4, 3'h0, 3'h1};
        logic [2:0] mk [5] = '{3'h7, 3'h3, 3'h3, 3'h0, 3'h0};
        for (int i = 0; i < 5; i++)
        begin
            mask_i = mk[i];
            interrupt_priority_lines_i = lv[i];
            step(3);
            cmp(irq_take_o, lv[i] != 0 && (lv[i] > mk[i] || lv[i] == 7));
            if (lv[i] != 0)
                cmp(irq_level_o, lv[i]);
        end
        interrupt_priority_lines_i = 3'h5;
        step(3);
        dly = 8'hFF;
        go(cbi_pkg::CT_INT_ACK, 1'b1, 1'b1);
        cmp(bus_o.addr, {cbi_pkg::ACK_ADDR_HIGH, 3'h5});
        sync_peripheral_select_i = 1'b1;
        wt(4);
        sync_peripheral_select_i = 1'b0;
        interrupt_priority_lines_i = 3'h0;
        step(4);
    endtask
    task automatic t_sync();
        dly = 8'hFF;
        go(cbi_pkg::CT_SUP_DATA, 1'b0, 1'b0);
        step(2);
        cmp(bus_o.valid_n, 1'b1);
        sync_peripheral_select_i = 1'b1;
        wt(5);
        wt(1);
        cmp(enable_o, 1'b0);
        sync_peripheral_select_i = 1'b0;
        step(2);
    endtask
    // Fault alone raises exception, with halt a rerun
    task automatic t_fault(input logic h);
        dly = 8'hFF;
        go(cbi_pkg::CT_USER_DATA, 1'b0, 1'b0);
        bus_fault_input_i = 1'b1;
        ext_halt = h;
        wt(h ? 3 : 2);
        cmp({fault_o, rerun_o}, h ? 2'h1 : 2'h2);
        dly = 8'h00;
        bus_fault_input_i = 1'b0;
        ext_halt = 1'b0;
        // Rerun means the core issues the faulted cycle again
        if (h)
            rd(cbi_pkg::CT_USER_DATA, 1'b0, 1'b0);
        step(4);
    endtask
    task automatic t_block(input logic g);
        logic r;
        r = 1'b0;
        ext_halt = !g;
        grant_acknowledge_input_i = g;
        step(6);
        req_valid_i = 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            step();
            r = r | req_ready_o;
        end
        req_valid_i = 1'b0;
        cmp(r, 1'b0);
        cmp({ctype_oe_o, data_oe_o}, 2'h0);
        cmp(bus_oe_o, !g);
        if (!g)
            t_enable();
        ext_halt = 1'b0;
        grant_acknowledge_input_i = 1'b0;
        step(2);
    endtask
    task automatic t_reset();
        int n;
        reset_instr_i = 1'b1;
        wt(6);
        reset_instr_i = 1'b0;
        step(5);
        cmp(sys_init_o, 1'b0);
        n = 5;
        while (reset_line_oe_o === 1'b1 && n < 300)
        begin
            step();
            n++;
        end
        cmp(n, 124);
        step(2);
        ext_reset = 1'b1;
        step(3);
        cmp(sys_init_o, 1'b1);
        cmp(full_reset_o, 1'b0);
        ext_halt = 1'b1;
        step(2);
        cmp(full_reset_o, 1'b1);
        ext_halt = 1'b0;
        ext_reset = 1'b0;
        stopped_i = 1'b1;
        step(3);
        cmp({halt_oe_o, halt_o}, 2'h3);
        stopped_i = 1'b0;
        step(4);
    endtask
    task automatic end_of_test();
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Main sequence after four reset cycles
    initial
    begin
        logic [2:0] cts [4] = '{cbi_pkg::CT_USER_DATA,
            cbi_pkg::CT_USER_PROG, cbi_pkg::CT_SUP_DATA,
            cbi_pkg::CT_SUP_PROG};
        step(4);
        rst_i = 1'b0;
        step();
        t_enable();
        for (int i = 0; i < 4; i++)
        begin
            dly = 8'(i * 2);
            rd(cts[i], 1'b0, 1'b0);
        end
        dly = 8'h00;
        rd(cbi_pkg::CT_SUP_DATA, 1'b1, 1'b0);
        rd(cbi_pkg::CT_SUP_DATA, 1'b1, 1'b1);
        t_sync();
        t_irq();
        t_fault(1'b0);
        t_fault(1'b1);
        t_block(1'b0);
        t_block(1'b1);
        t_reset();
        end_of_test();
    end
    // Watchdog well beyond the expected run length
    initial
    begin
        #(100 * 5000);
        n_mismatch++;
        end_of_test();
    end
endmodule
`default_nettype wire
